// [rtl/line_cfg_pkg.sv]
// Constants shared by the mute and line configuration register bank
package line_cfg_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SAMPLE_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [5:0] PATH_MUTE_IDX = 6'h0F;
  localparam logic [5:0] LINE_BEHAV_IDX = 6'h10;
  localparam logic [5:0] HOOK_STATUS_IDX = 6'h3F;
  localparam logic [7:0] PATH_MUTE_RESET = 8'h00;
  localparam logic [7:0] LINE_BEHAV_RESET = 8'h00;
  // Field positions
  localparam int unsigned OUTGOING_MUTE_BIT = 7;
  localparam int unsigned INCOMING_MUTE_BIT = 3;
  localparam int unsigned HANGUP_SPEED_BIT = 6;
  localparam int unsigned RECURSIVE_FILT_BIT = 4;
  localparam int unsigned RINGER_IMP_BIT = 1;
  localparam int unsigned RING_THRESH_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam int unsigned STAT_RSVD_BIT = 6;
  localparam logic [1:0] QUENCH_FIELD = 2'h3;
  localparam logic [1:0] NO_QUENCH_FIELD = 2'h0;
  // Release times
  localparam int unsigned QUENCH_RELEASE_US = 26_000;
  localparam int unsigned ETSI_RELEASE_US = 3_000;
  localparam int unsigned FAST_RELEASE_US = 500;
  localparam int unsigned QUENCH_RELEASE_CYC =
    QUENCH_RELEASE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ETSI_RELEASE_CYC =
    ETSI_RELEASE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FAST_RELEASE_CYC =
    FAST_RELEASE_US * (CLK_HZ / 1_000_000);
  // Silence codes for the two companding laws
  localparam logic [7:0] ULAW_SILENCE = 8'hFF;
  localparam logic [7:0] ALAW_SILENCE = 8'hD5;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PROFILE_FAST,
    PROFILE_ETSI,
    PROFILE_QUENCH
  } release_profile_e;
  typedef enum logic [1:0] {
    WINDOW_LOW,
    WINDOW_RESERVED,
    WINDOW_MID,
    WINDOW_HIGH
  } ring_window_e;
endpackage : line_cfg_pkg

// [rtl/sample_path_if.sv]
// Carrier for one voice sample stream between internal modules
`timescale 1ns/1ps
interface sample_path_if #(
  parameter int unsigned W = 8
);
  logic valid;
  logic [W-1:0] data;
  modport source (output valid, output data);
  modport sink (input valid, input data);
endinterface : sample_path_if

// [rtl/mute_stage.sv]
// One voice path stage that swaps samples for silence while muted
`timescale 1ns/1ps
module mute_stage #(
  parameter int unsigned W = 8
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic mute_in,
  input wire logic [W-1:0] silence_code_in,
  sample_path_if.sink up,
  sample_path_if.source down
);
  logic [W-1:0] next_data;

  // Timing is kept: every valid still yields one sample, only its value changes
  assign next_data = mute_in ? silence_code_in : up.data;

  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      down.valid <= 1'b0;
      down.data <= '0;
    end
    else
    begin
      down.valid <= up.valid;
      if (up.valid)
      begin
        down.data <= next_data;
      end
    end
  end
endmodule : mute_stage

// [rtl/mute_and_line_config_regs.sv]
// Mute and line behaviour control registers with AXI4-Lite access
`timescale 1ns/1ps
module mute_and_line_config_regs #(
  parameter int unsigned ADDR_W = line_cfg_pkg::ADDR_W,
  parameter int unsigned QUENCH_CYC = line_cfg_pkg::QUENCH_RELEASE_CYC,
  parameter int unsigned ETSI_CYC = line_cfg_pkg::ETSI_RELEASE_CYC,
  parameter int unsigned FAST_CYC = line_cfg_pkg::FAST_RELEASE_CYC
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic hangup_speed_sel_hi_in,
  input wire logic [1:0] spark_quench_field_in,
  input wire logic offhook_ctl_in,
  input wire logic ring_threshold_sel_hi_in,
  input wire logic alaw_sel_in,
  input wire logic [7:0] tx_sample_in,
  input wire logic tx_sample_valid_in,
  output logic [7:0] tx_sample_out,
  output logic tx_sample_valid_out,
  input wire logic [7:0] rx_sample_in,
  input wire logic rx_sample_valid_in,
  output logic [7:0] rx_sample_out,
  output logic rx_sample_valid_out,
  output logic outgoing_mute_out,
  output logic incoming_mute_out,
  output logic hangup_speed_sel_out,
  output logic recursive_filter_sel_out,
  output logic ringer_impedance_sel_out,
  output logic ring_threshold_sel_out,
  output logic [1:0] release_profile_out,
  output logic hook_release_busy_out,
  output logic hook_release_done_out,
  output logic [1:0] ring_window_out,
  output logic ring_threshold_reserved_out
);
  localparam int unsigned CNT_W = $clog2(QUENCH_CYC + 1) + 1;

  generate
    if (ADDR_W < 8)
    begin : g_bad_addr
      $error("ADDR_W too small for the register map");
    end
    if (QUENCH_CYC < 1 || ETSI_CYC < 1 || FAST_CYC < 1)
    begin : g_bad_cyc
      $error("Release counts must be at least one cycle");
    end
    if (ETSI_CYC > QUENCH_CYC || FAST_CYC > QUENCH_CYC)
    begin : g_bad_order
      $error("Quench release must be the longest count");
    end
  endgenerate

  // Stored register fields
  logic outgoing_mute;
  logic incoming_mute;
  logic hangup_speed_sel;
  logic recursive_filter_sel;
  logic ringer_impedance_sel;
  logic ring_threshold_sel;

  // Write channel state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Write decode
  logic aw_take;
  logic w_take;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic [ADDR_W-3:0] wr_idx;
  logic wr_mute_hit;
  logic wr_line_hit;
  logic wr_lane0;

  assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
  assign w_take = s_axi_wvalid_in && s_axi_wready_out;
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr_in;
  assign wr_data = w_held ? w_data : s_axi_wdata_in;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb_in;
  assign wr_fire = (aw_held || aw_take) && (w_held || w_take);
  assign wr_idx = wr_addr[ADDR_W-1:2];
  assign wr_mute_hit = wr_idx == (ADDR_W-2)'(line_cfg_pkg::PATH_MUTE_IDX);
  assign wr_line_hit = wr_idx == (ADDR_W-2)'(line_cfg_pkg::LINE_BEHAV_IDX);
  assign wr_lane0 = wr_fire && wr_strb[0];

  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      aw_held <= (aw_held || aw_take) && !wr_fire;
      w_held <= (w_held || w_take) && !wr_fire;
      if (aw_take)
      begin
        aw_addr <= s_axi_awaddr_in;
      end
      if (w_take)
      begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
    end
  end

  // Write response; the status register is read only and refuses writes
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= line_cfg_pkg::AXI_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (wr_mute_hit || wr_line_hit) ?
        line_cfg_pkg::AXI_OKAY : line_cfg_pkg::AXI_SLVERR;
    end
    else if (s_axi_bready_in)
    begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Register storage; only lane 0 carries the 8-bit fields
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      outgoing_mute <=
        line_cfg_pkg::PATH_MUTE_RESET[line_cfg_pkg::OUTGOING_MUTE_BIT];
      incoming_mute <=
        line_cfg_pkg::PATH_MUTE_RESET[line_cfg_pkg::INCOMING_MUTE_BIT];
      hangup_speed_sel <=
        line_cfg_pkg::LINE_BEHAV_RESET[line_cfg_pkg::HANGUP_SPEED_BIT];
      recursive_filter_sel <=
        line_cfg_pkg::LINE_BEHAV_RESET[line_cfg_pkg::RECURSIVE_FILT_BIT];
      ringer_impedance_sel <=
        line_cfg_pkg::LINE_BEHAV_RESET[line_cfg_pkg::RINGER_IMP_BIT];
      ring_threshold_sel <=
        line_cfg_pkg::LINE_BEHAV_RESET[line_cfg_pkg::RING_THRESH_BIT];
    end
    else if (wr_lane0 && wr_mute_hit)
    begin
      outgoing_mute <= wr_data[line_cfg_pkg::OUTGOING_MUTE_BIT];
      incoming_mute <= wr_data[line_cfg_pkg::INCOMING_MUTE_BIT];
    end
    else if (wr_lane0 && wr_line_hit)
    begin
      // Bits 7 and 5 are dropped here, so no value of theirs matters
      hangup_speed_sel <= wr_data[line_cfg_pkg::HANGUP_SPEED_BIT];
      recursive_filter_sel <= wr_data[line_cfg_pkg::RECURSIVE_FILT_BIT];
      ringer_impedance_sel <= wr_data[line_cfg_pkg::RINGER_IMP_BIT];
      ring_threshold_sel <= wr_data[line_cfg_pkg::RING_THRESH_BIT];
    end
  end

  // Release profile selection
  line_cfg_pkg::release_profile_e profile;
  logic quench_pick;
  logic etsi_pick;

  assign quench_pick = hangup_speed_sel &&
    spark_quench_field_in == line_cfg_pkg::QUENCH_FIELD;
  assign etsi_pick = !hangup_speed_sel && hangup_speed_sel_hi_in &&
    spark_quench_field_in == line_cfg_pkg::NO_QUENCH_FIELD;
  assign profile = quench_pick ? line_cfg_pkg::PROFILE_QUENCH :
    etsi_pick ? line_cfg_pkg::PROFILE_ETSI :
    line_cfg_pkg::PROFILE_FAST;

  // Release timer starts on the falling edge of the off-hook control
  logic offhook_prev;
  logic release_start;
  logic [CNT_W-1:0] release_cnt;
  logic [CNT_W-1:0] release_load;
  logic [CNT_W-1:0] next_release_cnt;

  assign release_start = offhook_prev && !offhook_ctl_in;

  always_comb
  begin
    case (profile)
      line_cfg_pkg::PROFILE_QUENCH: release_load = CNT_W'(QUENCH_CYC);
      line_cfg_pkg::PROFILE_ETSI: release_load = CNT_W'(ETSI_CYC);
      line_cfg_pkg::PROFILE_FAST: release_load = CNT_W'(FAST_CYC);
      default: release_load = CNT_W'(FAST_CYC);
    endcase
  end

  // Going off-hook again abandons a release in progress
  assign next_release_cnt = offhook_ctl_in ? '0 :
    release_start ? release_load :
    (release_cnt != '0) ? release_cnt - CNT_W'(1) : '0;

  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      offhook_prev <= 1'b0;
      release_cnt <= '0;
      hook_release_done_out <= 1'b0;
    end
    else
    begin
      offhook_prev <= offhook_ctl_in;
      release_cnt <= next_release_cnt;
      hook_release_done_out <= !offhook_ctl_in &&
        release_cnt == CNT_W'(1);
    end
  end

  assign hook_release_busy_out = release_cnt != '0;
  assign release_profile_out = profile;

  // Ring detection window
  assign ring_window_out = {ring_threshold_sel, ring_threshold_sel_hi_in};
  // The reserved combination is flagged but still passed on unchanged
  assign ring_threshold_reserved_out =
    !ring_threshold_sel && ring_threshold_sel_hi_in;

  // Control outputs
  assign outgoing_mute_out = outgoing_mute;
  assign incoming_mute_out = incoming_mute;
  assign hangup_speed_sel_out = hangup_speed_sel;
  assign recursive_filter_sel_out = recursive_filter_sel;
  assign ringer_impedance_sel_out = ringer_impedance_sel;
  assign ring_threshold_sel_out = ring_threshold_sel;

  // Read path
  logic ar_take;
  logic [ADDR_W-3:0] rd_idx;
  logic rd_mute_hit;
  logic rd_line_hit;
  logic rd_stat_hit;
  logic [7:0] mute_view;
  logic [7:0] line_view;
  logic [7:0] stat_view;
  logic [7:0] rd_byte;

  assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign rd_idx = s_axi_araddr_in[ADDR_W-1:2];
  assign rd_mute_hit = rd_idx == (ADDR_W-2)'(line_cfg_pkg::PATH_MUTE_IDX);
  assign rd_line_hit = rd_idx == (ADDR_W-2)'(line_cfg_pkg::LINE_BEHAV_IDX);
  assign rd_stat_hit = rd_idx == (ADDR_W-2)'(line_cfg_pkg::HOOK_STATUS_IDX);
  assign mute_view = {outgoing_mute, 3'h0, incoming_mute, 3'h0};
  assign line_view = {1'b0, hangup_speed_sel, 1'b0, recursive_filter_sel,
    2'h0, ringer_impedance_sel, ring_threshold_sel};
  assign stat_view = {hook_release_busy_out, ring_threshold_reserved_out,
    2'h0, ring_window_out, release_profile_out};
  assign rd_byte = rd_mute_hit ? mute_view :
    rd_line_hit ? line_view :
    rd_stat_hit ? stat_view : 8'h00;

  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= line_cfg_pkg::AXI_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h00_0000, rd_byte};
      s_axi_rresp_out <= (rd_mute_hit || rd_line_hit || rd_stat_hit) ?
        line_cfg_pkg::AXI_OKAY : line_cfg_pkg::AXI_SLVERR;
    end
    else if (s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // Voice paths
  logic [7:0] silence_code;
  sample_path_if #(.W(line_cfg_pkg::SAMPLE_W)) tx_up ();
  sample_path_if #(.W(line_cfg_pkg::SAMPLE_W)) tx_down ();
  sample_path_if #(.W(line_cfg_pkg::SAMPLE_W)) rx_up ();
  sample_path_if #(.W(line_cfg_pkg::SAMPLE_W)) rx_down ();

  assign silence_code = alaw_sel_in ? line_cfg_pkg::ALAW_SILENCE :
    line_cfg_pkg::ULAW_SILENCE;
  assign tx_up.valid = tx_sample_valid_in;
  assign tx_up.data = tx_sample_in;
  assign rx_up.valid = rx_sample_valid_in;
  assign rx_up.data = rx_sample_in;

  mute_stage #(.W(line_cfg_pkg::SAMPLE_W)) u_tx_mute (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .mute_in(outgoing_mute),
    .silence_code_in(silence_code),
    .up(tx_up),
    .down(tx_down)
  );

  mute_stage #(.W(line_cfg_pkg::SAMPLE_W)) u_rx_mute (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .mute_in(incoming_mute),
    .silence_code_in(silence_code),
    .up(rx_up),
    .down(rx_down)
  );

  assign tx_sample_out = tx_down.data;
  assign tx_sample_valid_out = tx_down.valid;
  assign rx_sample_out = rx_down.data;
  assign rx_sample_valid_out = rx_down.valid;
endmodule : mute_and_line_config_regs

// [tb/mute_line_assertions.sv]
// Port-level checks on the mute and line register bank
`timescale 1ns/1ps
module mute_line_assertions (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic offhook_ctl_in,
  input wire logic ring_threshold_sel_hi_in,
  input wire logic [1:0] spark_quench_field_in,
  input wire logic alaw_sel_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_wvalid_in,
  input wire logic tx_sample_valid_in,
  input wire logic [7:0] rx_sample_in,
  input wire logic rx_sample_valid_in,
  input wire logic [7:0] tx_sample_out,
  input wire logic tx_sample_valid_out,
  input wire logic [7:0] rx_sample_out,
  input wire logic outgoing_mute_out,
  input wire logic incoming_mute_out,
  input wire logic hangup_speed_sel_out,
  input wire logic recursive_filter_sel_out,
  input wire logic ringer_impedance_sel_out,
  input wire logic ring_threshold_sel_out,
  input wire logic [1:0] release_profile_out,
  input wire logic hook_release_busy_out,
  input wire logic hook_release_done_out,
  input wire logic [1:0] ring_window_out,
  input wire logic ring_threshold_reserved_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  chk_tx_silence_fill:
  assert property (tx_sample_valid_in && outgoing_mute_out && !alaw_sel_in
    |=> tx_sample_out == 8'hFF) else $error("muted sample not silence");
  chk_rx_pass_through:
  assert property (rx_sample_valid_in && !incoming_mute_out
    |=> rx_sample_out == $past(rx_sample_in)) else $error("rx data lost");
  chk_frame_timing:
  assert property (tx_sample_valid_out == $past(tx_sample_valid_in))
    else $error("sample timing moved");
  chk_quench_profile:
  assert property (hangup_speed_sel_out && spark_quench_field_in == 2'h3
    |-> release_profile_out == 2'h2) else $error("profile not quench");
  // Fast profile only: five cycles at the bench's shortened count
  chk_fast_release:
  assert property ($fell(offhook_ctl_in) && release_profile_out == 2'h0
    |=> hook_release_busy_out [*5] ##1
    (!hook_release_busy_out && hook_release_done_out))
    else $error("release length wrong");
  chk_ring_window:
  assert property (ring_window_out ==
    {ring_threshold_sel_out, ring_threshold_sel_hi_in})
    else $error("ring window wrong");
  chk_reserved_flag:
  assert property (ring_threshold_reserved_out ==
    (!ring_threshold_sel_out && ring_threshold_sel_hi_in))
    else $error("reserved combo flag wrong");
  chk_line_bits_hold:
  assert property (!s_axi_awvalid_in && !s_axi_wvalid_in
    |=> $stable({recursive_filter_sel_out, ringer_impedance_sel_out}))
    else $error("line bits moved without write");
endmodule : mute_line_assertions

bind mute_and_line_config_regs mute_line_assertions mute_line_assertions_i (
  .core_clk_in, .rstn_in, .offhook_ctl_in, .ring_threshold_sel_hi_in,
  .spark_quench_field_in, .alaw_sel_in, .s_axi_awvalid_in, .s_axi_wvalid_in,
  .tx_sample_valid_in, .rx_sample_in, .rx_sample_valid_in, .tx_sample_out,
  .tx_sample_valid_out, .rx_sample_out, .outgoing_mute_out,
  .incoming_mute_out, .hangup_speed_sel_out, .recursive_filter_sel_out,
  .ringer_impedance_sel_out, .ring_threshold_sel_out, .release_profile_out,
  .hook_release_busy_out, .hook_release_done_out, .ring_window_out,
  .ring_threshold_reserved_out);

// [tb/axi_host_model.sv]
// Host software model: AXI4-Lite master for register accesses
`timescale 1ns/1ps
module axi_host_model (
  input wire logic clk_in,
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  initial
  begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out} = '0;
    {bready_out, araddr_out, arvalid_out, rready_out} = '0;
  end
  // Unused bits are written with whatever the caller gives
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    awvalid_out <= 1;
    wvalid_out <= 1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk_in);
      // Released lines are inverted so no stale value looks valid
      if (awvalid_out && awready_in)
      begin
        aw_done = 1;
        awvalid_out <= 0;
        awaddr_out <= ~a;
      end
      if (wvalid_out && wready_in)
      begin
        w_done = 1;
        wvalid_out <= 0;
        wdata_out <= ~d;
      end
    end
    bready_out <= 1;
    do @(posedge clk_in); while (!bvalid_in);
    r = bresp_in;
    bready_out <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1;
    do @(posedge clk_in); while (!arready_in);
    arvalid_out <= 0;
    araddr_out <= ~a;
    rready_out <= 1;
    do @(posedge clk_in); while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 0;
  endtask : rd
endmodule : axi_host_model

// [tb/tb.sv]
// Self-checking bench for the mute and line register bank
`timescale 1ns/1ps
module tb;
  logic core_clk_in, rstn_in, hangup_speed_sel_hi_in, offhook_ctl_in;
  logic ring_threshold_sel_hi_in, alaw_sel_in, tx_sample_valid_in;
  logic rx_sample_valid_in, tx_sample_valid_out, rx_sample_valid_out;
  logic [1:0] spark_quench_field_in, release_profile_out, ring_window_out;
  logic [7:0] tx_sample_in, rx_sample_in, tx_sample_out, rx_sample_out;
  logic outgoing_mute_out, incoming_mute_out, hangup_speed_sel_out;
  logic recursive_filter_sel_out, ringer_impedance_sel_out;
  logic ring_threshold_sel_out, hook_release_busy_out;
  logic hook_release_done_out, ring_threshold_reserved_out;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp;
  logic awv, awr, wv, wrdy, bv, brd, arv, arr, rv, rrd;
  int bad_count, checks_done, cyc;
  // Short counts keep each release inside a few dozen cycles
  mute_and_line_config_regs #(.QUENCH_CYC(20), .ETSI_CYC(10), .FAST_CYC(5))
    mute_and_line_config_regs_i (.core_clk_in, .rstn_in,
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(brd), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd), .hangup_speed_sel_hi_in,
    .spark_quench_field_in, .offhook_ctl_in, .ring_threshold_sel_hi_in,
    .alaw_sel_in, .tx_sample_in, .tx_sample_valid_in, .tx_sample_out,
    .tx_sample_valid_out, .rx_sample_in, .rx_sample_valid_in, .rx_sample_out,
    .rx_sample_valid_out, .outgoing_mute_out, .incoming_mute_out,
    .hangup_speed_sel_out, .recursive_filter_sel_out,
    .ringer_impedance_sel_out, .ring_threshold_sel_out, .release_profile_out,
    .hook_release_busy_out, .hook_release_done_out, .ring_window_out,
    .ring_threshold_reserved_out);
  axi_host_model axi_host_model_i (.clk_in(core_clk_in), .awaddr_out(awa),
    .awvalid_out(awv), .awready_in(awr), .wdata_out(wd), .wvalid_out(wv),
    .wready_in(wrdy), .bresp_in(bresp), .bvalid_in(bv), .bready_out(brd),
    .araddr_out(ara), .arvalid_out(arv), .arready_in(arr), .rdata_in(rdat),
    .rresp_in(rresp), .rvalid_in(rv), .rready_out(rrd));
  initial
  begin
    core_clk_in = 0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic results;
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic w(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] e);
    logic [1:0] r;
    axi_host_model_i.wr(a, {24'h0, d}, r);
    chk(r, e);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [7:0] e,
    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] rs;
    axi_host_model_i.rd(a, d, rs);
    chk(d, {24'h0, e});
    chk(rs, er);
  endtask : r
  task automatic t_reset_vals;
    r(8'h3C, 8'h00, 2'h0);
    r(8'h40, 8'h00, 2'h0);
  endtask : t_reset_vals
  task automatic t_mute_bits;
    w(8'h3C, 8'hFF, 2'h0);
    r(8'h3C, 8'h88, 2'h0);
    chk(outgoing_mute_out, 1);
    w(8'h3C, 8'h08, 2'h0);
    chk(outgoing_mute_out, 0);
    chk(incoming_mute_out, 1);
  endtask : t_mute_bits
  task automatic t_line_bits;
    w(8'h40, 8'hFF, 2'h0);
    r(8'h40, 8'h53, 2'h0);
    chk({recursive_filter_sel_out, ringer_impedance_sel_out}, 2'h3);
    w(8'h40, 8'hA0, 2'h0);
    r(8'h40, 8'h00, 2'h0);
    chk({recursive_filter_sel_out, ringer_impedance_sel_out}, 2'h0);
  endtask : t_line_bits
  task automatic t_bad_addr;
    w(8'h80, 8'h01, 2'h2);
    r(8'h80, 8'h00, 2'h2);
    w(8'hFC, 8'hFF, 2'h2);
  endtask : t_bad_addr
  task automatic t_samples;
    w(8'h3C, 8'h80, 2'h0);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge core_clk_in);
      alaw_sel_in <= i[0];
      tx_sample_in <= 8'h12;
      rx_sample_in <= 8'h34;
      {tx_sample_valid_in, rx_sample_valid_in} <= 2'h3;
      @(posedge core_clk_in);
      {tx_sample_valid_in, rx_sample_valid_in} <= 2'h0;
      @(negedge core_clk_in);
      chk(tx_sample_out, i ? 8'hD5 : 8'hFF);
      chk(rx_sample_out, 8'h34);
      chk({tx_sample_valid_out, rx_sample_valid_out}, 2'h3);
      @(negedge core_clk_in);
      chk({tx_sample_valid_out, rx_sample_valid_out}, 2'h0);
    end
  endtask : t_samples
  task automatic t_ring;
    for (int i = 0; i < 4; i++)
    begin
      w(8'h40, {7'h0, i[1]}, 2'h0);
      ring_threshold_sel_hi_in <= i[0];
      @(negedge core_clk_in);
      chk(ring_window_out, i[1:0]);
      chk(ring_threshold_reserved_out, i == 1);
      // Status view: reserved flag, window 01, fast profile, idle timer
      if (i == 1) r(8'hFC, 8'h44, 2'h0);
    end
    ring_threshold_sel_hi_in <= 0;
  endtask : t_ring
  task automatic t_release;
    logic [7:0] dat [3] = '{8'h40, 8'h00, 8'h00};
    int n_cyc [3] = '{20, 10, 5};
    int n;
    int nd;
    for (int k = 0; k < 3; k++)
    begin
      w(8'h40, dat[k], 2'h0);
      hangup_speed_sel_hi_in <= (k == 1);
      spark_quench_field_in <= (k == 0) ? 2'h3 : 2'h0;
      offhook_ctl_in <= 1;
      repeat (2) @(posedge core_clk_in);
      chk(release_profile_out, 2 - k);
      offhook_ctl_in <= 0;
      n = 0;
      nd = 0;
      repeat (40)
      begin
        @(negedge core_clk_in);
        n += hook_release_busy_out;
        nd += hook_release_done_out;
      end
      chk(n, n_cyc[k]);
      chk(nd, 1);
    end
  endtask : t_release
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      results();
    end
  end
  initial
  begin
    {rstn_in, hangup_speed_sel_hi_in, offhook_ctl_in, alaw_sel_in} = '0;
    {ring_threshold_sel_hi_in, tx_sample_valid_in, rx_sample_valid_in} = '0;
    {spark_quench_field_in, tx_sample_in, rx_sample_in} = '0;
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1;
    t_reset_vals();
    t_mute_bits();
    t_line_bits();
    t_bad_addr();
    t_samples();
    t_ring();
    t_release();
    @(posedge core_clk_in);
    rstn_in <= 0;
    repeat (2) @(posedge core_clk_in);
    rstn_in <= 1;
    t_reset_vals();
    results();
  end
endmodule : tb
